// file: hdl/bidir_port_pkg.sv
// Constants shared by the bidirectional printer port block.
package bidir_port_pkg;

  // Register select codes on the two address lines
  localparam logic [1:0] ADDR_DATA_WORD = 2'h0;  // parallel_data_word, read and write
  localparam logic [1:0] ADDR_KEY_STATE = 2'h1;  // direction_key_write / port_state_read
  localparam logic [1:0] ADDR_DRIVE_RB  = 2'h2;  // output_line_drive / output_line_readback

  // Field positions of output_line_drive; all but BIT_FORCE_OUT shared by output_line_readback
  localparam int BIT_LATCH_PULSE = 0;
  localparam int BIT_AUTO_LF     = 1;
  localparam int BIT_RESTART     = 2;
  localparam int BIT_CHOOSE      = 3;
  localparam int BIT_IRQ_ENABLE  = 4;
  localparam int BIT_FORCE_OUT   = 5;

  // Field positions of port_state_read
  localparam int ST_ERROR   = 3;
  localparam int ST_IRQ_N   = 2;
  localparam int ST_ONLINE  = 4;
  localparam int ST_EMPTY   = 5;
  localparam int ST_ACK     = 6;
  localparam int ST_BUSY_N  = 7;

  // Fixed bit values
  localparam logic [1:0] ST_LOW_ONES = 2'h3;    // status bits 1..0
  localparam logic [2:0] RB_HIGH_ONES = 3'h7;   // readback bits 7..5
  localparam logic [7:0] UNMAPPED_READ = 8'hff; // address 11 reads as all ones

  // Key byte that selects input mode when the direction pin is low
  localparam logic [7:0] DIR_KEY_INPUT = 8'haa;

  // Values after reset
  localparam logic [7:0] RST_DATA_WORD = 8'h00;
  localparam logic [7:0] RST_DIR_KEY   = 8'h00;
  localparam logic       RST_LATCH_N   = 1'b1;
  localparam logic       RST_AUTO_LF_N = 1'b1;
  localparam logic       RST_CHOOSE_N  = 1'b1;
  localparam logic       RST_RESTART   = 1'b0;
  localparam logic       RST_IRQ_EN    = 1'b0;
  localparam logic       RST_FORCE_OUT = 1'b0;

endpackage

// file: hdl/fall_detect.sv
// Per-bit falling-edge detector for synchronous active-low levels.
`timescale 1ns/1ps
module fall_detect #(
  parameter int W = 3  // number of watched levels
) (
  input  wire logic         core_clk,  // system clock
  input  wire logic         rst,       // async reset, active high
  input  wire logic [W-1:0] level_in,  // watched levels
  output logic      [W-1:0] fall_out   // high for the cycle a level drops
);

  typedef struct packed {
    logic [W-1:0] prev;
  } fall_state_s;

  fall_state_s st_reg;
  fall_state_s st_next;

  if (W < 1) begin : g_width_check
    $error("fall_detect needs W >= 1");
  end

  // Idle-high reset, so a level already low at release gives an edge on the first cycle
  always_comb begin
    st_next.prev = level_in;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{prev: '1};
    end else begin
      st_reg <= st_next;
    end
  end

  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      assign fall_out[i] = st_reg.prev[i] & ~level_in[i];
    end
  endgenerate

endmodule

// file: hdl/bidir_printer_port.sv
// Register interface and pin logic of a bidirectional parallel printer port.
//
// Contract
// - Status bits 4,5,6 show online, media-empty, acknowledge levels uninverted.
// - Status bit 7 shows the busy input inverted.
// - Status bit 2 reads 0 while an interrupt is pending, else 1.
// - Readback shows the four control pins and irq enable in any direction.
// - Readback bits 0,1,3 are 1 for low pins; bit 2 high restart; bit 4 enable.
// - Readback bits 7 to 5 always read 1.
// - Control write bits 0,1,3 drive pins low when 1; bit 2 drives restart high.
// - Control bit 4 enables or disables the interrupt output.
// - Control bit 5 at 1 forces the data lines to output mode.
// - Direction pin low: only the key byte written selects input mode.
// - Direction pin high with bit 5 at 0 selects input mode, key ignored.
// - Address 00 data, 01 key/status, 10 control/readback.
// - A status read deasserts the interrupt output unless an acknowledge edge falls in the same cycle.
// - Reset floats irq, data lines output zero, strobes high, restart low.
// - Output mode drives written data; input mode reads sample the lines.
// - Each falling acknowledge edge makes an interrupt pending.
// - Status bit 3 shows error uninverted; bits 1 and 0 read 1.
`timescale 1ns/1ps
module bidir_printer_port
  import bidir_port_pkg::*;
#(
  parameter int DATA_W = 8  // width of host and parallel data
) (
  input  wire logic              core_clk,          // 40 MHz system clock
  input  wire logic              rst,               // async reset, active high
  // Host side
  input  wire logic              port_select_n,     // chip select, active low
  input  wire logic [1:0]        addr,              // register select
  input  wire logic              wr_n,              // write strobe, active low
  input  wire logic              rd_n,              // read strobe, active low
  input  wire logic [DATA_W-1:0] host_data_in,      // host data bus, in
  output logic      [DATA_W-1:0] host_data_out,     // host data bus, out
  output logic                   host_data_oe_n,    // host bus drive, low drives
  output logic                   port_irq_out,      // interrupt level, high pending
  output logic                   port_irq_oe_n,     // interrupt drive, low drives
  // Printer side
  input  wire logic [DATA_W-1:0] parallel_data_in,  // data lines, sampled
  output logic      [DATA_W-1:0] parallel_data_out, // data lines, driven value
  output logic                   parallel_data_oe_n,// data lines drive, low drives
  input  wire logic              direction_pin,     // high allows input mode
  input  wire logic              printer_online_in, // online-select input
  input  wire logic              media_empty_in,    // media-empty input
  input  wire logic              ack_n,             // acknowledge input, active low
  input  wire logic              busy_in,           // busy input
  input  wire logic              error_n,           // error input, active low
  output logic                   latch_pulse_n,     // data latch pulse, active low
  output logic                   auto_line_feed_n,  // auto line feed, active low
  output logic                   printer_restart,   // restart line, high level
  output logic                   printer_choose_n   // printer select, active low
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic              latch_n;
    logic              alf_n;
    logic              restart;
    logic              choose_n;
    logic              irq_en;
    logic              force_out;
    logic [7:0]        dir_key;
    logic [DATA_W-1:0] data_word;
    logic              pending;
    logic              irq_val;
    logic              irq_oe_n;
    logic [DATA_W-1:0] pd_out;
    logic              pd_oe_n;
    logic [DATA_W-1:0] host_out;
    logic              host_oe_n;
  } port_state_s;

  localparam port_state_s STATE_RST = '{
    latch_n:   RST_LATCH_N,
    alf_n:     RST_AUTO_LF_N,
    restart:   RST_RESTART,
    choose_n:  RST_CHOOSE_N,
    irq_en:    RST_IRQ_EN,
    force_out: RST_FORCE_OUT,
    dir_key:   RST_DIR_KEY,
    data_word: RST_DATA_WORD,
    pending:   1'b0,
    irq_val:   1'b0,
    irq_oe_n:  1'b1,
    pd_out:    RST_DATA_WORD,
    pd_oe_n:   1'b0,
    host_out:  '0,
    host_oe_n: 1'b1
  };

  port_state_s st_reg;
  port_state_s st_next;

  // Field positions in the package assume one byte on both sides
  if (DATA_W != 8) begin : g_width_check
    $error("bidir_printer_port supports DATA_W == 8 only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access and acknowledge edge detection

  logic       rd_active;
  logic       wr_active;
  logic [2:0] falls;
  logic       ack_fall;
  logic       rd_start;
  logic       wr_start;

  assign rd_active = ~port_select_n & ~rd_n;
  assign wr_active = ~port_select_n & ~wr_n;

  // An access is taken once, at the cycle its strobe is first seen low
  fall_detect #(
    .W (3)
  ) u_falls (
    .core_clk (core_clk),
    .rst      (rst),
    .level_in ({ack_n, ~rd_active, ~wr_active}),
    .fall_out (falls)
  );

  assign ack_fall = falls[2];
  assign rd_start = falls[1];
  assign wr_start = falls[0];

  ////////////////////////////////////////////////////////////////////////////
  // Read views

  logic [7:0] status_view;
  logic [7:0] readback_view;
  logic       input_mode;

  always_comb begin
    status_view                 = '0;
    status_view[1:0]            = ST_LOW_ONES;
    status_view[ST_IRQ_N]       = ~st_reg.pending;
    status_view[ST_ERROR]       = error_n;
    status_view[ST_ONLINE]      = printer_online_in;
    status_view[ST_EMPTY]       = media_empty_in;
    status_view[ST_ACK]         = ack_n;
    status_view[ST_BUSY_N]      = ~busy_in;
  end

  // Built from the pin flops, so it reads the same in either direction
  always_comb begin
    readback_view                  = '0;
    readback_view[7:5]             = RB_HIGH_ONES;
    readback_view[BIT_LATCH_PULSE] = ~st_reg.latch_n;
    readback_view[BIT_AUTO_LF]     = ~st_reg.alf_n;
    readback_view[BIT_RESTART]     = st_reg.restart;
    readback_view[BIT_CHOOSE]      = ~st_reg.choose_n;
    readback_view[BIT_IRQ_ENABLE]  = st_reg.irq_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next = st_reg;

    // Writes land on the first cycle of the strobe
    if (wr_start) begin
      unique case (addr)
        ADDR_DATA_WORD: begin
          st_next.data_word = host_data_in;
        end
        ADDR_KEY_STATE: begin
          st_next.dir_key = host_data_in;
        end
        ADDR_DRIVE_RB: begin
          st_next.latch_n   = ~host_data_in[BIT_LATCH_PULSE];
          st_next.alf_n     = ~host_data_in[BIT_AUTO_LF];
          st_next.restart   = host_data_in[BIT_RESTART];
          st_next.choose_n  = ~host_data_in[BIT_CHOOSE];
          st_next.irq_en    = host_data_in[BIT_IRQ_ENABLE];
          st_next.force_out = host_data_in[BIT_FORCE_OUT];
        end
        default: begin
          // Address 11 has no write target
        end
      endcase
    end

    // Reads latch their answer once so a status clear cannot alter it mid-read
    if (rd_start) begin
      unique case (addr)
        ADDR_DATA_WORD: begin
          st_next.host_out = input_mode ? parallel_data_in
                                        : st_reg.data_word;
        end
        ADDR_KEY_STATE: begin
          st_next.host_out = status_view;
        end
        ADDR_DRIVE_RB: begin
          st_next.host_out = readback_view;
        end
        default: begin
          st_next.host_out = UNMAPPED_READ;
        end
      endcase
    end
    st_next.host_oe_n = ~rd_active;

    // A new acknowledge edge beats a status-read clear in the same cycle
    if (rd_start && addr == ADDR_KEY_STATE) begin
      st_next.pending = 1'b0;
    end
    if (ack_fall) begin
      st_next.pending = 1'b1;
    end

    // Interrupt pin floats while disabled
    st_next.irq_val  = st_next.pending;
    st_next.irq_oe_n = ~st_next.irq_en;

    // Direction recomputed every cycle from the latest controls
    st_next.pd_out  = st_next.data_word;
    st_next.pd_oe_n = ~(st_next.force_out |
                        (~direction_pin &
                         (st_next.dir_key != DIR_KEY_INPUT)));
  end

  // Input mode is the inverse of the registered drive enable
  assign input_mode = st_reg.pd_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign host_data_out      = st_reg.host_out;
  assign host_data_oe_n     = st_reg.host_oe_n;
  assign port_irq_out       = st_reg.irq_val;
  assign port_irq_oe_n      = st_reg.irq_oe_n;
  assign parallel_data_out  = st_reg.pd_out;
  assign parallel_data_oe_n = st_reg.pd_oe_n;
  assign latch_pulse_n      = st_reg.latch_n;
  assign auto_line_feed_n   = st_reg.alf_n;
  assign printer_restart    = st_reg.restart;
  assign printer_choose_n   = st_reg.choose_n;

endmodule

// file: dv/bidir_printer_port_sva.sv
// Assertion checker for the printer port register and pin behaviour.
`timescale 1ns/1ps
module bidir_printer_port_chk #(
  parameter int DATA_W = 8  // data width
) (
  input wire logic              core_clk,           // clock
  input wire logic              rst,                // reset
  input wire logic              port_select_n,      // select
  input wire logic [1:0]        addr,               // register select
  input wire logic              wr_n,               // write strobe
  input wire logic              rd_n,               // read strobe
  input wire logic [DATA_W-1:0] host_data_in,       // write data
  input wire logic [DATA_W-1:0] host_data_out,      // read data
  input wire logic              port_irq_out,       // irq level
  input wire logic              port_irq_oe_n,      // irq drive
  input wire logic [DATA_W-1:0] parallel_data_out,  // line value
  input wire logic              parallel_data_oe_n, // line drive
  input wire logic              printer_online_in,  // online
  input wire logic              media_empty_in,     // empty
  input wire logic              ack_n,              // acknowledge
  input wire logic              busy_in,            // busy
  input wire logic              error_n,            // error
  input wire logic              latch_pulse_n,      // latch pin
  input wire logic              auto_line_feed_n,   // line feed pin
  input wire logic              printer_restart,    // restart pin
  input wire logic              printer_choose_n    // choose pin
);
  logic act_q;
  wire  act = !port_select_n && !(rd_n && wr_n);
  wire  rd1 = act && !act_q && !rd_n;
  wire  wr1 = act && !act_q && !wr_n;
  // Held strobes count once, so only the first cycle of an access is a start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) act_q <= 1'b0;
    else act_q <= act;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_pins: assert property (
    $fell(rst) |-> port_irq_oe_n && latch_pulse_n && auto_line_feed_n && printer_choose_n
      && !printer_restart && !parallel_data_oe_n && parallel_data_out == '0)
    else $error("pins not at reset state");
  a_status_word: assert property (
    rd1 && addr == 2'h1 |=> host_data_out[7:3] == {!$past(busy_in), $past(ack_n),
      $past(media_empty_in), $past(printer_online_in), $past(error_n)}
      && host_data_out[1:0] == 2'h3)
    else $error("status word wrong");
  a_irq_flag: assert property (
    rd1 && addr == 2'h1 |=> host_data_out[2] == !$past(port_irq_out))
    else $error("status irq flag wrong");
  a_status_clear: assert property (
    rd1 && addr == 2'h1 && ack_n |=> !port_irq_out)
    else $error("status read left irq set");
  a_ack_sets: assert property ($fell(ack_n) |=> port_irq_out)
    else $error("ack fall did not set irq");
  a_readback_word: assert property (
    rd1 && addr == 2'h2 |=> host_data_out[7:0] == {3'h7, !$past(port_irq_oe_n),
      !$past(printer_choose_n), $past(printer_restart), !$past(auto_line_feed_n),
      !$past(latch_pulse_n)})
    else $error("readback word wrong");
  a_drive_pins: assert property (
    wr1 && addr == 2'h2 |=> {port_irq_oe_n, printer_choose_n, printer_restart,
      auto_line_feed_n, latch_pulse_n} == ~($past(host_data_in[4:0]) ^ 5'h04))
    else $error("control pins wrong");
  a_force_out: assert property (
    wr1 && addr == 2'h2 && host_data_in[5] |=> !parallel_data_oe_n)
    else $error("force bit did not select output");
  a_data_drive: assert property (
    wr1 && addr == 2'h0 |=> parallel_data_out == $past(host_data_in))
    else $error("data word not driven");
  a_unmapped_read: assert property (rd1 && addr == 2'h3 |=> host_data_out == '1)
    else $error("unmapped read wrong");
  c_irq_set: cover property ($fell(ack_n) ##1 port_irq_out);
  c_input_mode: cover property ($rose(parallel_data_oe_n));
  c_irq_clear: cover property (rd1 && addr == 2'h1 && port_irq_out);
endmodule
bind bidir_printer_port bidir_printer_port_chk #(.DATA_W(DATA_W)) u_chk (.core_clk, .rst,
  .port_select_n, .addr, .wr_n, .rd_n, .host_data_in, .host_data_out, .port_irq_out,
  .port_irq_oe_n, .parallel_data_out, .parallel_data_oe_n, .printer_online_in,
  .media_empty_in, .ack_n, .busy_in, .error_n, .latch_pulse_n, .auto_line_feed_n,
  .printer_restart, .printer_choose_n);

// file: dv/printer_model.sv
// Behavioural printer on the far side of the data and handshake lines.
`timescale 1ns/1ps
module printer_model (
  input  wire logic       core_clk,           // clock
  input  wire logic       rst,                // reset
  input  wire logic [7:0] parallel_data_out,  // device line value
  input  wire logic       parallel_data_oe_n, // device drives when low
  input  wire logic       latch_pulse_n,      // latch pulse
  input  wire logic [7:0] line_val,           // byte offered in input mode
  input  wire logic [3:0] st_val,             // busy, empty, online, error_n
  input  wire logic       ack_go,             // start an acknowledge
  input  wire logic [3:0] ack_len,            // acknowledge length, cycles
  output logic      [7:0] parallel_data_in,   // resolved lines
  output logic            ack_n,              // acknowledge
  output logic            busy_in,            // busy
  output logic            media_empty_in,     // empty
  output logic            printer_online_in,  // online
  output logic            error_n,            // error
  output logic      [7:0] got_byte            // last latched byte
);
  logic [3:0] cnt_reg;
  // The printer drives only once the device has released the lines
  assign parallel_data_in = parallel_data_oe_n ? line_val : parallel_data_out;
  assign {busy_in, media_empty_in, printer_online_in, error_n} = st_val;
  assign ack_n = (cnt_reg == 4'h0);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      got_byte <= 8'h00;
    end else begin
      if (ack_go) cnt_reg <= ack_len;
      else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
      if (!latch_pulse_n) got_byte <= parallel_data_in;
    end
  end
endmodule

// file: dv/bidir_printer_port_tb_top.sv
// Self-checking testbench for the bidirectional printer port.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module bidir_printer_port_tb_top;
  import bidir_port_pkg::*;
  logic        core_clk = 1'b0, rst = 1'b1, port_select_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
  logic        direction_pin = 1'b0, ack_go = 1'b0, en;
  logic [1:0]  addr = 2'h0;
  logic [3:0]  st_val = 4'h5, ack_len = 4'h1;
  logic [7:0]  host_data_in = 8'h00, line_val = 8'h00, q, c, d, host_data_out;
  logic [7:0]  parallel_data_in, parallel_data_out, got_byte;
  logic        host_data_oe_n, port_irq_out, port_irq_oe_n, parallel_data_oe_n, ack_n;
  logic        printer_online_in, media_empty_in, busy_in, error_n, latch_pulse_n;
  logic        auto_line_feed_n, printer_restart, printer_choose_n;
  logic [31:0] seed = 32'h0000e669;
  int          err_total = 0, samples_checked = 0;
  wire  [4:0]  ctl_pins = {port_irq_oe_n, printer_choose_n, printer_restart, auto_line_feed_n,
                           latch_pulse_n};
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  bidir_printer_port u_dut (.core_clk, .rst, .port_select_n, .addr, .wr_n, .rd_n,
    .host_data_in, .host_data_out, .host_data_oe_n, .port_irq_out, .port_irq_oe_n,
    .parallel_data_in, .parallel_data_out, .parallel_data_oe_n, .direction_pin,
    .printer_online_in, .media_empty_in, .ack_n, .busy_in, .error_n, .latch_pulse_n,
    .auto_line_feed_n, .printer_restart, .printer_choose_n);
  printer_model u_prn (.core_clk, .rst, .parallel_data_out, .parallel_data_oe_n,
    .latch_pulse_n, .line_val, .st_val, .ack_go, .ack_len, .parallel_data_in, .ack_n,
    .busy_in, .media_empty_in, .printer_online_in, .error_n, .got_byte);
  ////////////////////////////////////////////////////////////////////////////////
  function logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function logic [7:0] st_exp(input logic [3:0] s, input logic pend);
    return {~s[3], 1'b1, s[2], s[1], s[0], ~pend, ST_LOW_ONES};
  endfunction
  // One access: strobe held three edges, sampled after the second so the answer has landed, then a gap
  task acc(input logic w, input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk);
    port_select_n <= 1'b0;
    addr <= a;
    host_data_in <= v;
    if (w) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 q = host_data_out;
    `CHK(host_data_oe_n, w)
    @(posedge core_clk);
    port_select_n <= 1'b1;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    // Callers then compare clear of the edge that launched the outputs
    @(posedge core_clk);
    #1 `CHK(host_data_oe_n, 1'b1)
  endtask
  task dir_case(input logic f, input logic p, input logic [7:0] k);
    logic exp_in;
    exp_in = !f && (p || k == DIR_KEY_INPUT);
    acc(1'b1, ADDR_DRIVE_RB, {2'h0, f, 5'h00});
    acc(1'b1, ADDR_KEY_STATE, k);
    @(posedge core_clk);
    direction_pin <= p;
    line_val <= rnd();
    repeat (2) @(posedge core_clk);
    #1 `CHK(parallel_data_oe_n, exp_in)
    // Output mode must still return the stored word, not the lines
    acc(1'b0, ADDR_DATA_WORD, 8'h00);
    `CHK(q, exp_in ? line_val : d)
  endtask
  task give_verdict();
    $display("errors %0d, comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    $display("mismatch at %0t: run did not finish", $time);
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1 `CHK({ctl_pins, parallel_data_oe_n, parallel_data_out}, {5'h1b, 1'b0, 8'h00})
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk);
      c = rnd();
      st_val <= c[3:0];
      c = rnd();
      acc(1'b1, ADDR_DRIVE_RB, c);
      `CHK(ctl_pins, ~(c[4:0] ^ 5'h04))
      acc(1'b1, 2'h3, rnd());
      acc(1'b0, ADDR_DRIVE_RB, 8'h00);
      `CHK(q, {RB_HIGH_ONES, c[4:0]})
      acc(1'b0, ADDR_KEY_STATE, 8'h00);
      `CHK(q, st_exp(st_val, 1'b0))
      acc(1'b0, 2'h3, 8'h00);
      `CHK(q, UNMAPPED_READ)
    end
    d = rnd();
    acc(1'b1, ADDR_DRIVE_RB, 8'h20);
    acc(1'b1, ADDR_DATA_WORD, d);
    `CHK(parallel_data_out, d)
    acc(1'b1, ADDR_DRIVE_RB, 8'h21);
    acc(1'b1, ADDR_DRIVE_RB, 8'h20);
    `CHK(got_byte, d)
    acc(1'b0, ADDR_DATA_WORD, 8'h00);
    `CHK(q, d)
    for (int k = 0; k < 2; k++) begin
      en = k[0];
      acc(1'b1, ADDR_DRIVE_RB, {3'h1, en, 4'h0});
      @(posedge core_clk);
      c = rnd();
      ack_go <= 1'b1;
      ack_len <= {1'b0, c[2:0]} + 4'h1;
      @(posedge core_clk);
      ack_go <= 1'b0;
      repeat (12) @(posedge core_clk);
      #1 `CHK({port_irq_out, port_irq_oe_n}, {1'b1, ~en})
      acc(1'b0, ADDR_KEY_STATE, 8'h00);
      `CHK(q, st_exp(st_val, 1'b1))
      `CHK(port_irq_out, 1'b0)
      acc(1'b0, ADDR_KEY_STATE, 8'h00);
      `CHK(q[ST_IRQ_N], 1'b1)
    end
    for (int i = 0; i < 8; i++) begin
      dir_case(i[0], i[1], i[2] ? DIR_KEY_INPUT : (rnd() | 8'h01));
    end
    give_verdict();
  end
endmodule
